// ==== shared/pfs_params.svh ====
// timing and reset constants for the pwm forced-stop block
// assumes a 20 MHz clk; included by bare name
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH
`define PFS_CLK_NS 50
`define PFS_PWM_PERIOD_NS 20000
`define PFS_PWM_PERIOD_CYC (`PFS_PWM_PERIOD_NS / `PFS_CLK_NS)
`define PFS_PWM_DUTY_PCT 50
`define PFS_PWM_HIGH_CYC ((`PFS_PWM_PERIOD_CYC * `PFS_PWM_DUTY_PCT) / 100)
`define PFS_TICK_MS 10
`define PFS_TICK_CYC ((`PFS_TICK_MS * 1000000) / `PFS_CLK_NS)
`define PFS_OUT_RESET 1'h0
`endif

// ==== shared/pfs_pkg.sv ====
// types for the pwm forced-stop block
// assumes nothing beyond a SystemVerilog compiler
package pfs_pkg;
  // state of each forced-stop function
  typedef enum logic [1:0] {STOP_IDLE, STOP_HELD, STOP_ARMED} pfs_stop_t;
  // synchronised fault inputs carried together
  typedef struct packed {
    logic cmpHigh;
    logic ovLevel;
    logic restart;
  } pfs_fault_t;
endpackage : pfs_pkg

// ==== verilog/pfs_forced_stop.sv ====
// pwm timer with two hardware forced-stop functions and an interval tick
// assumes async pins sampled by three flops; one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "pfs_params.svh"

module pfs_forced_stop
  import pfs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic currentComparator,
  input wire logic overvoltageStopInput,
  input wire logic restartTriggerInput,
  input wire logic stop1ReleaseTrigger,
  output logic pwmOutputPin,
  output logic stop1Active,
  output logic stop2Active,
  output logic intervalTick
);

  localparam int PER = `PFS_PWM_PERIOD_CYC;
  localparam int HIGH = `PFS_PWM_HIGH_CYC;
  localparam int TICK = `PFS_TICK_CYC;

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [2:0] cmpSync_q;
  logic [2:0] ovSync_q;
  logic [2:0] rstSync_q;
  pfs_fault_t flt_q;
  pfs_fault_t fltPrev_q;

  // three flops; level accepted when stages two and three agree
  // over-voltage resets high: a pin high at reset release is no trip, a pin low there trips
  // comparator and restart reset low: no false rising edge after reset
  // only stages two and three feed the filter, stage one may be metastable
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      cmpSync_q <= 3'h0;
      ovSync_q <= 3'h7;
      rstSync_q <= 3'h0;
    end
    else
    begin
      cmpSync_q <= {cmpSync_q[1:0], currentComparator};
      ovSync_q <= {ovSync_q[1:0], overvoltageStopInput};
      rstSync_q <= {rstSync_q[1:0], restartTriggerInput};
    end

  // filtered levels and their previous values
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      flt_q <= '{cmpHigh: 1'b0, ovLevel: 1'b1, restart: 1'b0};
      fltPrev_q <= '{cmpHigh: 1'b0, ovLevel: 1'b1, restart: 1'b0};
    end
    else
    begin
      if (cmpSync_q[2] == cmpSync_q[1]) flt_q.cmpHigh <= cmpSync_q[2];
      if (ovSync_q[2] == ovSync_q[1]) flt_q.ovLevel <= ovSync_q[2];
      if (rstSync_q[2] == rstSync_q[1]) flt_q.restart <= rstSync_q[2];
      fltPrev_q <= flt_q;
    end

  logic cmpRise;
  logic ovFall;
  logic ovRise;
  logic restartRise;
  assign cmpRise = flt_q.cmpHigh & ~fltPrev_q.cmpHigh;
  assign ovFall = ~flt_q.ovLevel & fltPrev_q.ovLevel;
  assign ovRise = flt_q.ovLevel & ~fltPrev_q.ovLevel;
  assign restartRise = flt_q.restart & ~fltPrev_q.restart;

  // ************************************************
  // pwm counter
  // ************************************************
  logic [9:0] cnt_q;
  logic periodEnd;
  assign periodEnd = (cnt_q == 10'(PER - 1));

  // free-running period counter, cleared by restart trigger
  // count 0 to half period minus one drives high, rest drives low
  // last count marks where an armed stop may lift
  // restart wins over a natural wrap in the same cycle
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      cnt_q <= 10'h000;
    else if (restartRise || periodEnd)
      cnt_q <= 10'h000;
    else
      cnt_q <= cnt_q + 10'h001;

  // ************************************************
  // forced-stop functions
  // ************************************************
  pfs_stop_t stop1_q;
  pfs_stop_t stop2_q;

  // stop one: over-current path, release by software pulse
  // held: waits for release pulse with comparator level low
  // armed: waits for period end; a new trip returns to held
  // a release pulse in idle or with comparator high is ignored
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      stop1_q <= STOP_IDLE;
    else
      case (stop1_q)
        STOP_IDLE:
          if (cmpRise) stop1_q <= STOP_HELD;
        STOP_HELD:
          if (stop1ReleaseTrigger && !flt_q.cmpHigh) stop1_q <= STOP_ARMED;
        STOP_ARMED:
          if (cmpRise) stop1_q <= STOP_HELD;
          else if (periodEnd) stop1_q <= STOP_IDLE;
        default:
          stop1_q <= STOP_IDLE;
      endcase

  // stop two: over-voltage path, release after rising edge
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      stop2_q <= STOP_IDLE;
    else
      case (stop2_q)
        STOP_IDLE:
          if (ovFall) stop2_q <= STOP_HELD;
        STOP_HELD:
          if (ovRise) stop2_q <= STOP_ARMED;
        STOP_ARMED:
          if (ovFall) stop2_q <= STOP_HELD;
          else if (periodEnd) stop2_q <= STOP_IDLE;
        default:
          stop2_q <= STOP_IDLE;
      endcase

  // any stop not idle, including a trip seen this cycle
  logic stop1Now;
  logic stop2Now;
  assign stop1Now = (stop1_q != STOP_IDLE) || cmpRise;
  assign stop2Now = (stop2_q != STOP_IDLE) || ovFall;

  // ************************************************
  // output stage
  // ************************************************
  // compare waveform gated by both stops
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      pwmOutputPin <= `PFS_OUT_RESET;
      stop1Active <= 1'b0;
      stop2Active <= 1'b0;
    end
    else
    begin
      pwmOutputPin <= (cnt_q < 10'(HIGH)) && !restartRise && !stop1Now && !stop2Now;
      stop1Active <= stop1Now;
      stop2Active <= stop2Now;
    end

  // ************************************************
  // interval timer channel
  // ************************************************
  logic [17:0] tickCnt_q;

  // 10 ms tick pulse
  // free-running, not tied to the pwm counter or to restart
  // pulse lasts one cycle, first one a full interval after reset
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tickCnt_q <= 18'h00000;
      intervalTick <= 1'b0;
    end
    else
    begin
      intervalTick <= (tickCnt_q == 18'(TICK - 1));
      tickCnt_q <= (tickCnt_q == 18'(TICK - 1)) ? 18'h00000 : tickCnt_q + 18'h00001;
    end

endmodule : pfs_forced_stop
`default_nettype wire

// ==== bench/pfs_power_stage.sv ====
// power stage model: measures gate high time and period
// assumes gate is the registered pwm output on clk
`timescale 1ns/1ps
`default_nettype none
module pfs_power_stage (
  input wire logic clk,
  input wire logic rstn,
  input wire logic gate,
  output logic [15:0] highLen,
  output logic [15:0] periodLen
);
  logic [15:0] hiCnt_q;
  logic [15:0] perCnt_q;
  logic gate_q;
  // count cycles between rises and while high
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {hiCnt_q, perCnt_q, highLen, periodLen, gate_q} <= '0;
    end
    else
    begin
      gate_q <= gate;
      perCnt_q <= (gate && !gate_q) ? 16'h0001 : perCnt_q + 16'h0001;
      hiCnt_q <= (gate && !gate_q) ? 16'h0001 : hiCnt_q + {15'h0000, gate};
      if (gate && !gate_q) periodLen <= perCnt_q;
      if (!gate && gate_q) highLen <= hiCnt_q;
    end
  end
endmodule : pfs_power_stage
`default_nettype wire

// ==== bench/pfs_forced_stop_props.sv ====
// port assertions for the pwm forced-stop block
// assumes it is bound onto pfs_forced_stop
`timescale 1ns/1ps
`default_nettype none
module pfs_forced_stop_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic currentComparator,
  input wire logic overvoltageStopInput,
  input wire logic restartTriggerInput,
  input wire logic stop1ReleaseTrigger,
  input wire logic pwmOutputPin,
  input wire logic stop1Active,
  input wire logic stop2Active,
  input wire logic intervalTick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_stop_forces_low: assert property ((stop1Active || stop2Active) |-> !pwmOutputPin)
    else $error("pwm high while stopped");
  a_stop1_trip: assert property ($rose(currentComparator) |-> ##[2:8] stop1Active)
    else $error("stop one missed trip");
  a_stop2_trip: assert property ($fell(overvoltageStopInput) |-> ##[2:8] stop2Active)
    else $error("stop two missed trip");
  a_stop1_hold: assert property ((stop1Active && currentComparator) [*6] |=> stop1Active)
    else $error("stop one lifted early");
  a_stop2_hold: assert property ((stop2Active && !overvoltageStopInput) [*6] |=> stop2Active)
    else $error("stop two lifted early");
  a_release_at_period: assert property ($fell(stop1Active) |-> pwmOutputPin [*8])
    else $error("release not at period start");
  a_restart_period: assert property ($rose(restartTriggerInput) && !stop1Active && !stop2Active
    |-> ##[2:8] (!pwmOutputPin ##1 pwmOutputPin))
    else $error("restart missed");
  a_tick_pulse: assert property (intervalTick |=> !intervalTick)
    else $error("tick too long");
  // main scenarios
  c_stop1: cover property ($fell(stop1Active));
  c_stop2: cover property ($fell(stop2Active));
  c_restart: cover property ($rose(restartTriggerInput));
endmodule : pfs_forced_stop_props
bind pfs_forced_stop pfs_forced_stop_props i_props (.clk, .rstn, .currentComparator,
  .overvoltageStopInput, .restartTriggerInput, .stop1ReleaseTrigger, .pwmOutputPin,
  .stop1Active, .stop2Active, .intervalTick);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the pwm forced-stop block
// assumes pfs_pkg compiled first and a 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rstn, cmp, ov, rst, rel, pwm, s1, s2, tick;
  logic [15:0] hiLen, perLen;
  int error_cnt, comparisons;
  pfs_forced_stop i_dut (.clk(clk), .rstn(rstn), .currentComparator(cmp),
    .overvoltageStopInput(ov), .restartTriggerInput(rst), .stop1ReleaseTrigger(rel),
    .pwmOutputPin(pwm), .stop1Active(s1), .stop2Active(s2), .intervalTick(tick));
  pfs_power_stage i_load (.clk(clk), .rstn(rstn), .gate(pwm), .highLen(hiLen),
    .periodLen(perLen));
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task close_out;
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task t_stop1;
    @(posedge clk) cmp <= 1'h1;
    cyc(8);
    chk(s1, 16'h0001); chk(pwm, 16'h0000);
    @(posedge clk) rel <= 1'h1;
    @(posedge clk) rel <= 1'h0;
    cyc(450);
    chk(s1, 16'h0001);
    @(posedge clk) cmp <= 1'h0;
    cyc(8);
    @(posedge clk) rel <= 1'h1;
    @(posedge clk) rel <= 1'h0;
    for (int i = 0; i < 450 && s1 === 1'h1; i++) cyc(1);
    chk(s1, 16'h0000); chk(pwm, 16'h0001);
  endtask : t_stop1
  task t_stop2;
    @(posedge clk) ov <= 1'h0;
    cyc(458);
    chk(s2, 16'h0001); chk(pwm, 16'h0000);
    @(posedge clk) ov <= 1'h1;
    for (int i = 0; i < 450 && s2 === 1'h1; i++) cyc(1);
    chk(s2, 16'h0000); chk(pwm, 16'h0001);
  endtask : t_stop2
  task t_restart;
    for (int i = 0; i < 450 && pwm === 1'h1; i++) cyc(1);
    for (int i = 0; i < 450 && pwm === 1'h0; i++) cyc(1);
    cyc(50);
    @(posedge clk) rst <= 1'h1;
    for (int i = 0; i < 12 && pwm === 1'h1; i++) cyc(1);
    for (int i = 0; i < 12 && pwm === 1'h0; i++) cyc(1);
    chk(pwm, 16'h0001);
    @(posedge clk) rst <= 1'h0;
    cyc(190);
    chk(pwm, 16'h0001);
  endtask : t_restart
  // watchdog well beyond the expected run
  initial
  begin
    #500000;
    error_cnt++;
    close_out;
  end
  initial
  begin
    {cmp, rst, rel, rstn} = 4'h0;
    ov = 1'h1;
    error_cnt = 0;
    comparisons = 0;
    cyc(5);
    @(posedge clk) rstn <= 1'h1;
    cyc(1000);
    chk(hiLen, 16'h00C8); chk(perLen, 16'h0190);
    chk(tick, 16'h0000);
    t_stop1;
    t_stop2;
    t_restart;
    close_out;
  end
endmodule : testbench
`default_nettype wire
